// file: src/clkout_ctrl_regs.sv
// clock output control register bank with output format control
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Notes on behaviour
// - sleep powers down all outputs and internal circuitry.
// - during sleep both output format selections are ignored.
// - output two format: 1 off, 2 cmos, 3 low lvds, 5 lvpecl, 6 cml, 7 lvds.
// - output one format: as output two but with no cml code.
// - the cmos format forbids bypass on that output.
// - alarm reference: 0 external, 1 clock input one, 2 input two.
// - output two hold: 00 run, 01 static low, 10 static high.
// - output one hold: 00 run, 01 static low, 10 static high.
// - hold entry and exit give no glitch or runt pulse.
// - bits 7 to 3 set the holdover history averaging time.
// - bit 3 powers down output two buffer and its low-speed divider.
// - bit 2 powers down output one buffer and its low-speed divider.
// ----------------------------------------------------------------
module clkout_ctrl_regs
   import clkout_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic bypass_req,
   input wire logic clk_src_one,
   input wire logic clk_src_two,
   output logic clock_output_one,
   output logic clock_output_two,
   output logic [2:0] out1_buf_fmt,
   output logic [2:0] out2_buf_fmt,
   output logic out1_bypass_en,
   output logic out2_bypass_en,
   output logic out1_low_speed_divider_pd,
   output logic out2_low_speed_divider_pd,
   output logic out1_buffer_pd,
   output logic out2_buffer_pd,
   output logic core_powerdown,
   output logic [2:0] offset_alarm_ref_sel,
   output logic offset_alarm_ref_valid,
   output logic [4:0] holdover_avg_time
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] sleep_fmt_ff, nxt_sleep_fmt;
   logic [7:0] alarm_ref_ff, nxt_alarm_ref;
   logic [7:0] hold_ff, nxt_hold;
   logic [7:0] avg_ff, nxt_avg;
   logic [7:0] pwrdn_ff, nxt_pwrdn;
   logic [7:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;

   // masked write: reserved bits always rebuilt from the reset value
   function automatic logic [7:0] merge(input logic [7:0] wdata,
                                        input logic [7:0] mask,
                                        input logic [7:0] rst);
      merge = (wdata & mask) | (rst & ~mask);
   endfunction

   // format decode, cml allowed only where the output offers it
   function automatic buf_fmt_e decode_fmt(input logic [2:0] code,
                                           input logic cml_ok);
      unique case (code)
         FMT_CMOS: decode_fmt = BUF_CMOS;
         FMT_LVDS_LOW: decode_fmt = BUF_LVDS_LOW;
         FMT_LVPECL: decode_fmt = BUF_LVPECL;
         FMT_LVDS: decode_fmt = BUF_LVDS;
         FMT_CML: decode_fmt = cml_ok ? BUF_CML : BUF_OFF;
         // disable and the reserved codes keep the buffer off
         default: decode_fmt = BUF_OFF;
      endcase
   endfunction

   always_comb begin
      nxt_sleep_fmt = sleep_fmt_ff;
      nxt_alarm_ref = alarm_ref_ff;
      nxt_hold = hold_ff;
      nxt_avg = avg_ff;
      nxt_pwrdn = pwrdn_ff;
      if (reg_wr) begin
         unique case (reg_addr)
            SLEEP_FMT_ADDR: begin
               nxt_sleep_fmt = merge(reg_wdata, SLEEP_FMT_WMASK,
                                     SLEEP_FMT_RST);
            end
            ALARM_REF_ADDR: begin
               nxt_alarm_ref = merge(reg_wdata, ALARM_REF_WMASK,
                                     ALARM_REF_RST);
            end
            STATIC_HOLD_ADDR: begin
               nxt_hold = merge(reg_wdata, STATIC_HOLD_WMASK,
                                STATIC_HOLD_RST);
            end
            HOLDOVER_AVG_TIME_ADDR: begin
               nxt_avg = merge(reg_wdata, HOLDOVER_AVG_TIME_WMASK, HOLDOVER_AVG_TIME_RST);
            end
            PWRDN_ADDR: begin
               nxt_pwrdn = merge(reg_wdata, PWRDN_WMASK, PWRDN_RST);
            end
            default: begin
            end
         endcase
      end
      nxt_rvalid = reg_rd;
      nxt_rdata = rdata_ff;
      if (reg_rd) begin
         unique case (reg_addr)
            SLEEP_FMT_ADDR: nxt_rdata = sleep_fmt_ff;
            ALARM_REF_ADDR: nxt_rdata = alarm_ref_ff;
            STATIC_HOLD_ADDR: nxt_rdata = hold_ff;
            HOLDOVER_AVG_TIME_ADDR: nxt_rdata = avg_ff;
            PWRDN_ADDR: nxt_rdata = pwrdn_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sleep_fmt_ff <= SLEEP_FMT_RST;
         alarm_ref_ff <= ALARM_REF_RST;
         hold_ff <= STATIC_HOLD_RST;
         avg_ff <= HOLDOVER_AVG_TIME_RST;
         pwrdn_ff <= PWRDN_RST;
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         sleep_fmt_ff <= nxt_sleep_fmt;
         alarm_ref_ff <= nxt_alarm_ref;
         hold_ff <= nxt_hold;
         avg_ff <= nxt_avg;
         pwrdn_ff <= nxt_pwrdn;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;

   // ----------------------------------------------------------------
   // output control
   // ----------------------------------------------------------------
   logic sleep;
   logic [2:0] out1_code, out2_code;
   logic [2:0] out1_fmt_ff, nxt_out1_fmt;
   logic [2:0] out2_fmt_ff, nxt_out2_fmt;
   logic [7:0] misc_ff, nxt_misc;
   logic [2:0] ref_code;
   logic ref_ok;
   logic gated_one, gated_two;

   always_comb begin
      sleep = sleep_fmt_ff[SLEEP_BIT];
      out1_code = sleep_fmt_ff[OUT1_FMT_LSB +: 3];
      out2_code = sleep_fmt_ff[OUT2_FMT_LSB +: 3];
      ref_code = alarm_ref_ff[ALARM_REF_LSB +: 3];
      ref_ok = (ref_code == REF_EXTERNAL) || (ref_code == REF_CLKIN_ONE) ||
               (ref_code == REF_CLKIN_TWO);
      nxt_out1_fmt = decode_fmt(out1_code, 1'b0);
      nxt_out2_fmt = decode_fmt(out2_code, 1'b1);
      // sleep wins over either format selection
      if (sleep || pwrdn_ff[OUT1_PD_BIT]) begin
         nxt_out1_fmt = BUF_OFF;
      end
      if (sleep || pwrdn_ff[OUT2_PD_BIT]) begin
         nxt_out2_fmt = BUF_OFF;
      end
      nxt_misc[0] = sleep;
      nxt_misc[1] = sleep || pwrdn_ff[OUT1_PD_BIT];
      nxt_misc[2] = sleep || pwrdn_ff[OUT2_PD_BIT];
      // bypass is withheld from cmos and from a stopped output
      nxt_misc[3] = bypass_req && (nxt_out1_fmt != BUF_CMOS) &&
                    (nxt_out1_fmt != BUF_OFF);
      nxt_misc[4] = bypass_req && (nxt_out2_fmt != BUF_CMOS) &&
                    (nxt_out2_fmt != BUF_OFF);
      nxt_misc[5] = ref_ok;
      nxt_misc[7:6] = 2'h0;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         out1_fmt_ff <= BUF_OFF;
         out2_fmt_ff <= BUF_OFF;
         misc_ff <= 8'h00;
      end else begin
         out1_fmt_ff <= nxt_out1_fmt;
         out2_fmt_ff <= nxt_out2_fmt;
         misc_ff <= nxt_misc;
      end
   end

   clkout_gate u_gate_one (
      .core_clk(core_clk),
      .reset(reset),
      .clk_in(clk_src_one),
      .hold_sel(hold_ff[OUT1_HOLD_LSB +: 2]),
      .clk_out(gated_one)
   );

   clkout_gate u_gate_two (
      .core_clk(core_clk),
      .reset(reset),
      .clk_in(clk_src_two),
      .hold_sel(hold_ff[OUT2_HOLD_LSB +: 2]),
      .clk_out(gated_two)
   );

   // a powered-down buffer drives low
   assign clock_output_one = gated_one && (out1_fmt_ff != BUF_OFF);
   assign clock_output_two = gated_two && (out2_fmt_ff != BUF_OFF);
   assign out1_buf_fmt = out1_fmt_ff;
   assign out2_buf_fmt = out2_fmt_ff;
   assign core_powerdown = misc_ff[0];
   assign out1_buffer_pd = misc_ff[1];
   assign out1_low_speed_divider_pd = misc_ff[1];
   assign out2_buffer_pd = misc_ff[2];
   assign out2_low_speed_divider_pd = misc_ff[2];
   assign out1_bypass_en = misc_ff[3];
   assign out2_bypass_en = misc_ff[4];
   assign offset_alarm_ref_valid = misc_ff[5];
   assign offset_alarm_ref_sel = ref_code;
   assign holdover_avg_time = avg_ff[HOLDOVER_AVG_TIME_LSB +: 5];
endmodule

// file: src/clkout_regs_pkg.sv
// register map, field layout and encodings of the clock output control bank
package clkout_regs_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] SLEEP_FMT_ADDR = 8'h06;
   localparam logic [7:0] ALARM_REF_ADDR = 8'h07;
   localparam logic [7:0] STATIC_HOLD_ADDR = 8'h08;
   localparam logic [7:0] HOLDOVER_AVG_TIME_ADDR = 8'h09;
   localparam logic [7:0] PWRDN_ADDR = 8'h0a;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SLEEP_FMT_RST = 8'h2d;
   localparam logic [7:0] ALARM_REF_RST = 8'h2a;
   localparam logic [7:0] STATIC_HOLD_RST = 8'h00;
   localparam logic [7:0] HOLDOVER_AVG_TIME_RST = 8'hc0;
   localparam logic [7:0] PWRDN_RST = 8'h00;
   // ----------------------------------------------------------------
   // writable bit masks; all other bits are reserved
   // ----------------------------------------------------------------
   localparam logic [7:0] SLEEP_FMT_WMASK = 8'h7f;
   localparam logic [7:0] ALARM_REF_WMASK = 8'h07;
   localparam logic [7:0] STATIC_HOLD_WMASK = 8'hf0;
   localparam logic [7:0] HOLDOVER_AVG_TIME_WMASK = 8'hf8;
   localparam logic [7:0] PWRDN_WMASK = 8'h0c;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SLEEP_BIT = 6;
   localparam int OUT2_FMT_LSB = 3;
   localparam int OUT1_FMT_LSB = 0;
   localparam int ALARM_REF_LSB = 0;
   localparam int OUT2_HOLD_LSB = 6;
   localparam int OUT1_HOLD_LSB = 4;
   localparam int HOLDOVER_AVG_TIME_LSB = 3;
   localparam int OUT2_PD_BIT = 3;
   localparam int OUT1_PD_BIT = 2;
   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] FMT_DISABLE = 3'h1;
   localparam logic [2:0] FMT_CMOS = 3'h2;
   localparam logic [2:0] FMT_LVDS_LOW = 3'h3;
   localparam logic [2:0] FMT_LVPECL = 3'h5;
   localparam logic [2:0] FMT_CML = 3'h6;
   localparam logic [2:0] FMT_LVDS = 3'h7;
   localparam logic [2:0] REF_EXTERNAL = 3'h0;
   localparam logic [2:0] REF_CLKIN_ONE = 3'h1;
   localparam logic [2:0] REF_CLKIN_TWO = 3'h2;
   localparam logic [1:0] HOLD_NORMAL = 2'h0;
   localparam logic [1:0] HOLD_LOW = 2'h1;
   localparam logic [1:0] HOLD_HIGH = 2'h2;
   // buffer format code driven to the analog output stage
   typedef enum logic [2:0] {
      BUF_OFF = 3'h0,
      BUF_CMOS = 3'h1,
      BUF_LVDS_LOW = 3'h3,
      BUF_LVDS = 3'h2,
      BUF_LVPECL = 3'h6,
      BUF_CML = 3'h7
   } buf_fmt_e;
endpackage

// file: src/clkout_gate.sv
// glitch-free static-level hold for one clock output
`timescale 1ns/10ps
module clkout_gate
   import clkout_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_in,
   input wire logic [1:0] hold_sel,
   output logic clk_out
);
   // ----------------------------------------------------------------
   // hold request is only adopted while the clock sits at the target
   // level, so the edge never gets cut short
   // ----------------------------------------------------------------
   logic hold_ff, nxt_hold;
   logic level_ff, nxt_level;
   logic clk_q_ff;
   logic want_hold, want_level;

   always_comb begin
      want_hold = (hold_sel == HOLD_LOW) || (hold_sel == HOLD_HIGH);
      want_level = (hold_sel == HOLD_HIGH);
      nxt_hold = hold_ff;
      nxt_level = level_ff;
      // switch only when the running clock equals the held level
      if (!hold_ff && want_hold && (clk_q_ff == want_level)) begin
         nxt_hold = 1'b1;
         nxt_level = want_level;
      end else if (hold_ff && !want_hold && (clk_q_ff == level_ff)) begin
         nxt_hold = 1'b0;
      end else if (hold_ff && want_hold && want_level != level_ff &&
                   clk_q_ff == want_level) begin
         nxt_level = want_level;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         hold_ff <= 1'b0;
         level_ff <= 1'b0;
         clk_q_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
         level_ff <= nxt_level;
         clk_q_ff <= clk_in;
      end
   end

   // 11 is reserved and treated as normal running
   assign clk_out = hold_ff ? level_ff : clk_q_ff;
endmodule

// file: verif/clkout_chk_checker.sv
// assertion checker for the clock output control bank
`timescale 1ns/10ps
module clkout_chk
   import clkout_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rvalid,
   input wire logic clk_src_one,
   input wire logic clock_output_one,
   input wire logic [2:0] out1_buf_fmt,
   input wire logic [2:0] out2_buf_fmt,
   input wire logic out1_bypass_en,
   input wire logic out2_bypass_en,
   input wire logic out1_buffer_pd,
   input wire logic out2_buffer_pd,
   input wire logic out1_low_speed_divider_pd,
   input wire logic out2_low_speed_divider_pd,
   input wire logic core_powerdown,
   input wire logic [2:0] offset_alarm_ref_sel,
   input wire logic offset_alarm_ref_valid,
   input wire logic [4:0] holdover_avg_time
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   // output one only counts as live while powered and formatted
   logic live1;
   assign live1 = !out1_buffer_pd && out1_buf_fmt != BUF_OFF;
   a_rvalid_pulse: assert property (
      !$past(reset) |-> reg_rvalid == $past(reg_rd))
      else $error("read answer not one cycle after strobe");
   a_sleep_off: assert property (
      core_powerdown |-> out1_buf_fmt == BUF_OFF && out2_buf_fmt == BUF_OFF
         && out1_buffer_pd && out2_buffer_pd)
      else $error("sleep left an output running");
   a_pd_one_div: assert property (
      out1_buffer_pd |-> out1_low_speed_divider_pd)
      else $error("output one divider alive while buffer down");
   a_pd_two_div: assert property (
      out2_buffer_pd |-> out2_low_speed_divider_pd)
      else $error("output two divider alive while buffer down");
   a_cmos_no_bypass: assert property (
      out1_buf_fmt == BUF_CMOS |-> !out1_bypass_en)
      else $error("bypass allowed in cmos format");
   a_cmos_byp_two: assert property (
      out2_buf_fmt == BUF_CMOS |-> !out2_bypass_en)
      else $error("bypass allowed in cmos format on output two");
   a_ref_sel_write: assert property (
      reg_wr && reg_addr == ALARM_REF_ADDR
         |=> offset_alarm_ref_sel == $past(reg_wdata[2:0]))
      else $error("alarm reference field not written");
   a_ref_valid_dec: assert property (
      !$past(reset) |->
         offset_alarm_ref_valid == ($past(offset_alarm_ref_sel) <= 3'h2))
      else $error("alarm reference validity wrong");
   a_avg_time_write: assert property (
      reg_wr && reg_addr == HOLDOVER_AVG_TIME_ADDR
         |=> holdover_avg_time == $past(reg_wdata[7:3]))
      else $error("averaging time field not written");
   a_clk_no_runt: assert property (
      $changed(clock_output_one) && live1 && $past(live1)
         |-> clock_output_one == $past(clk_src_one))
      else $error("output one edge not taken from source");
endmodule
bind clkout_ctrl_regs clkout_chk i_chk (
   .core_clk(core_clk),
   .reset(reset),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rvalid(reg_rvalid),
   .clk_src_one(clk_src_one),
   .clock_output_one(clock_output_one),
   .out1_buf_fmt(out1_buf_fmt),
   .out2_buf_fmt(out2_buf_fmt),
   .out1_bypass_en(out1_bypass_en),
   .out2_bypass_en(out2_bypass_en),
   .out1_buffer_pd(out1_buffer_pd),
   .out2_buffer_pd(out2_buffer_pd),
   .out1_low_speed_divider_pd(out1_low_speed_divider_pd),
   .out2_low_speed_divider_pd(out2_low_speed_divider_pd),
   .core_powerdown(core_powerdown),
   .offset_alarm_ref_sel(offset_alarm_ref_sel),
   .offset_alarm_ref_valid(offset_alarm_ref_valid),
   .holdover_avg_time(holdover_avg_time)
);

// file: verif/tb.sv
// self-checking bench for the clock output control bank
`timescale 1ns/10ps
module tb;
   import clkout_regs_pkg::*;
   logic core_clk, reset, reg_wr, reg_rd, bypass_req, reg_rvalid;
   logic clk_src_one, clk_src_two, clock_output_one, clock_output_two;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] out1_buf_fmt, out2_buf_fmt, offset_alarm_ref_sel;
   logic out1_bypass_en, out2_bypass_en, core_powerdown;
   logic out1_low_speed_divider_pd, out2_low_speed_divider_pd;
   logic out1_buffer_pd, out2_buffer_pd, offset_alarm_ref_valid;
   logic [4:0] holdover_avg_time;
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   integer seed = 32'hec51;
   logic [7:0] exp_q[$];
   logic [7:0] rst_v[5] = '{SLEEP_FMT_RST, ALARM_REF_RST, STATIC_HOLD_RST,
      HOLDOVER_AVG_TIME_RST, PWRDN_RST};
   logic [7:0] msk_v[5] = '{SLEEP_FMT_WMASK, ALARM_REF_WMASK,
      STATIC_HOLD_WMASK, HOLDOVER_AVG_TIME_WMASK, PWRDN_WMASK};
   clkout_ctrl_regs i_dut (
      .core_clk(core_clk),
      .reset(reset),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .bypass_req(bypass_req),
      .clk_src_one(clk_src_one),
      .clk_src_two(clk_src_two),
      .clock_output_one(clock_output_one),
      .clock_output_two(clock_output_two),
      .out1_buf_fmt(out1_buf_fmt),
      .out2_buf_fmt(out2_buf_fmt),
      .out1_bypass_en(out1_bypass_en),
      .out2_bypass_en(out2_bypass_en),
      .out1_low_speed_divider_pd(out1_low_speed_divider_pd),
      .out2_low_speed_divider_pd(out2_low_speed_divider_pd),
      .out1_buffer_pd(out1_buffer_pd),
      .out2_buffer_pd(out2_buffer_pd),
      .core_powerdown(core_powerdown),
      .offset_alarm_ref_sel(offset_alarm_ref_sel),
      .offset_alarm_ref_valid(offset_alarm_ref_valid),
      .holdover_avg_time(holdover_avg_time)
   );
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // extra trailing cycle lets the decoded outputs catch up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      exp_q.push_back(e);
      @(negedge core_clk);
      reg_rd = 1'b0;
   endtask
   function automatic logic [2:0] fmt(input logic [2:0] c, input logic cml);
      case (c)
         3'h2: return BUF_CMOS;
         3'h3: return BUF_LVDS_LOW;
         3'h5: return BUF_LVPECL;
         3'h6: return cml ? BUF_CML : BUF_OFF;
         3'h7: return BUF_LVDS;
         default: return BUF_OFF;
      endcase
   endfunction
   // ----------------------------------------------------------------
   // sources, read monitor and timeout
   // ----------------------------------------------------------------
   always @(negedge core_clk) begin
      clk_src_one <= ~clk_src_one;
      clk_src_two <= 1'($random(seed));
   end
   // sampled mid-cycle so the registered answer is settled
   always @(negedge core_clk) begin
      cycles++;
      if (reg_rvalid === 1'b1 && exp_q.size() > 0)
         chk(reg_rdata, exp_q.pop_front());
      if (cycles == 5000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      logic [7:0] a;
      logic [7:0] d;
      logic [2:0] f1;
      logic [2:0] f2;
      logic [7:0] sv;
      logic [7:0] ev;
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      bypass_req = 1'b0;
      clk_src_one = 1'b0;
      clk_src_two = 1'b0;
      repeat (12) @(negedge core_clk);
      reset = 1'b0;
      wr(8'h05, 8'hff);
      wr(8'h0b, 8'hff);
      for (int i = 0; i < 5; i++)
         rd(SLEEP_FMT_ADDR + 8'(i), rst_v[i]);
      rd(8'h0b, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         a = SLEEP_FMT_ADDR + 8'(i);
         for (int k = 0; k < 3; k++) begin
            d = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($random(seed));
            wr(a, d);
            rd(a, (d & msk_v[i]) | (rst_v[i] & ~msk_v[i]));
            if (i == 3)
               chk({3'h0, holdover_avg_time}, {3'h0, d[7:3]});
         end
         wr(a, rst_v[i]);
      end
      $display("test reserved bits done");
      bypass_req = 1'b1;
      for (int c = 0; c < 8; c++) begin
         wr(SLEEP_FMT_ADDR, {2'b00, 3'(c), 3'(c)});
         f1 = fmt(3'(c), 1'b0);
         f2 = fmt(3'(c), 1'b1);
         chk({5'h0, out1_buf_fmt}, {5'h0, f1});
         chk({5'h0, out2_buf_fmt}, {5'h0, f2});
         ev = {6'h0, f2 != BUF_CMOS && f2 != BUF_OFF,
            f1 != BUF_CMOS && f1 != BUF_OFF};
         chk({6'h0, out2_bypass_en, out1_bypass_en}, ev);
         wr(SLEEP_FMT_ADDR, {2'b01, 3'(c), 3'(c)});
         sv = {core_powerdown, out1_buffer_pd, out2_buffer_pd,
            out1_low_speed_divider_pd, out2_low_speed_divider_pd,
            out1_buf_fmt};
         chk(sv, 8'hf8);
         sv = {out2_buf_fmt, clock_output_one, clock_output_two, 3'h0};
         chk(sv, 8'h00);
      end
      wr(SLEEP_FMT_ADDR, SLEEP_FMT_RST);
      $display("test formats and sleep done");
      for (int c = 0; c < 8; c++) begin
         wr(ALARM_REF_ADDR, (8'($random(seed)) & 8'hf8) | 8'(c));
         sv = {4'h0, offset_alarm_ref_valid, offset_alarm_ref_sel};
         chk(sv, {4'h0, c < 3, 3'(c)});
      end
      for (int c = 0; c < 4; c++) begin
         wr(PWRDN_ADDR, 8'(c << 2));
         sv = {4'h0, out1_buffer_pd, out1_low_speed_divider_pd,
            out2_buffer_pd, out2_low_speed_divider_pd};
         chk(sv, {4'h0, c[0], c[0], c[1], c[1]});
         sv = {6'h0, out2_buf_fmt == BUF_OFF, out1_buf_fmt == BUF_OFF};
         chk(sv, {6'h0, c[1], c[0]});
      end
      wr(PWRDN_ADDR, 8'h00);
      $display("test alarm and powerdown done");
      // the second source is random, so hold entry may wait a while
      for (int h = 1; h < 3; h++) begin
         wr(STATIC_HOLD_ADDR, {2'(h), 2'(h), 4'h0});
         repeat (16) @(negedge core_clk);
         repeat (6) begin
            @(negedge core_clk);
            sv = {6'h0, clock_output_two, clock_output_one};
            chk(sv, {6'h0, h == 2, h == 2});
         end
         wr(STATIC_HOLD_ADDR, 8'h00);
         repeat (8) @(negedge core_clk);
         sv = {6'h0, clock_output_two, clock_output_one};
         chk(sv, {6'h0, clk_src_two, clk_src_one});
      end
      $display("test static hold done");
      repeat (2) @(negedge core_clk);
      chk(8'(exp_q.size()), 8'h00);
      close_out();
   end
endmodule
